// [hdl/eum_top.sv]
// Endpoint user ports: maintenance requests and receive steering
// Behaviour
// [RL1] IO port condensed or initiator/target style
// [RL2] Each channel selects uniform-header or stream format
// [RL3] Uniform format: header is its own transfer
// [RL4] Stream format: packet passes complete, unaltered
// [RL5] Messages use message port or IO port
// [RL6] Custom port carries stream format only
// [RL7] Unsupported received types go to custom port
// [RL8] Maintenance port: register slave or remote-only stream
// [RL9] Maintenance accesses are four bytes only
// [RL10] Remote header fields come from info register
// [RL11] Transaction ID increments per remote request
// [RL12] User rewrites info only when fields change
// [RL13] All configuration accesses pass through fabric
// [RL14] Fabric is master, layer blocks are slaves
// [RL15] Register bits numbered little-endian, leftmost is 31
// [RL16] Event request pulse sends one symbol
// [RL17] Link reset held until port drops
// [RL18] Bad addresses: writes dropped, reads zero
// [RL19] Beats move only when valid and ready
`timescale 1ns/1ns
module eum_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port configuration
    input wire logic io_it,
    input wire logic msg_on_io,
    input wire logic maint_lite,
    input wire logic [eum_pkg::CH_N-1:0] fmt_hello,
    // Maintenance request
    input wire logic mreq_valid,
    output logic mreq_ready,
    input wire logic mreq_write,
    input wire logic mreq_remote,
    input wire logic [eum_pkg::AW-1:0] mreq_addr,
    input wire logic [eum_pkg::DW-1:0] mreq_wdata,
    // Maintenance response
    output logic mrsp_valid,
    output logic mrsp_err,
    output logic [eum_pkg::DW-1:0] mrsp_rdata,
    // Request information register
    input wire logic info_wr,
    input wire logic [eum_pkg::DW-1:0] info_wdata,
    // Outgoing remote maintenance header
    output logic hdr_valid,
    input wire logic hdr_ready,
    output logic hdr_write,
    output logic [15:0] hdr_destid,
    output logic [7:0] hdr_tid,
    output logic [1:0] hdr_prio,
    output logic hdr_crf,
    output logic [eum_pkg::AW-1:0] hdr_addr,
    output logic [eum_pkg::DW-1:0] hdr_wdata,
    // Maintenance originated by the link partner
    input wire logic lnk_valid,
    output logic lnk_ready,
    input wire logic lnk_write,
    input wire logic [eum_pkg::AW-1:0] lnk_addr,
    input wire logic [eum_pkg::DW-1:0] lnk_wdata,
    output logic lnk_rsp_valid,
    output logic [eum_pkg::DW-1:0] lnk_rsp_rdata,
    // Configuration slaves
    output logic [eum_pkg::SLV_N-1:0] cs_valid,
    output logic cs_write,
    output logic [eum_pkg::AW-1:0] cs_addr,
    output logic [eum_pkg::DW-1:0] cs_wdata,
    input wire logic [eum_pkg::SLV_N-1:0] cs_ready,
    input wire logic [eum_pkg::SLV_N*eum_pkg::DW-1:0] cs_rdata,
    // Received packet stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [eum_pkg::RDW-1:0] rx_data,
    input wire logic rx_last,
    // Steered receive channels
    output logic out_valid,
    output eum_pkg::eum_chan_t out_chan,
    output logic [eum_pkg::RDW-1:0] out_data,
    output logic out_last,
    output logic out_hdr,
    input wire logic [eum_pkg::CH_N-1:0] out_ready,
    // Link control symbols
    input wire logic mce_req,
    output logic mce_send,
    input wire logic lrst_req,
    output logic lrst_send
);
    import eum_pkg::*;

    // Receive channel for a first beat
    function automatic eum_chan_t chan_of(input logic [3:0] ft,
            input logic [3:0] tt, input logic it, input logic mio);
        eum_chan_t io_req;
        io_req = it ? CH_TREQ : CH_IO_RX; // RL1
        unique case (ft)
            FT_NREAD, FT_NWRITE, FT_SWRITE, FT_DBELL: chan_of = io_req;
            FT_MSG: chan_of = mio ? io_req : CH_MSG_TREQ; // RL5
            FT_RESP: chan_of = (tt == TT_MSG_RSP && !mio) ? CH_MSG_IRESP
                             : (it ? CH_IRESP : CH_IO_RX);
            default: chan_of = CH_USER;
        endcase
    endfunction

    logic [15:0] inf_dest;
    logic [1:0] inf_prio;
    logic inf_crf;
    logic [7:0] tid_cnt;
    logic pref_lnk;
    logic own_lnk;
    logic loc_busy;
    logic sop;
    logic out_sop;
    logic fab_ready;
    logic fab_rsp;
    logic [DW-1:0] fab_rdata;

    // Request classification and arbitration into the fabric
    wire mis = |mreq_addr[ALN_BITS-1:0];
    wire bad = mis || (!maint_lite && !mreq_remote);
    wire hdr_free = !hdr_valid || hdr_ready;
    wire loc_want = mreq_valid && !bad && !mreq_remote;
    wire pick_lnk = lnk_valid && (pref_lnk || !loc_want);
    wire fab_valid = loc_want || lnk_valid;
    wire fab_take = fab_valid && fab_ready;
    wire loc_go = fab_ready && loc_want && !pick_lnk;
    assign lnk_ready = fab_ready && pick_lnk; // RL13
    assign mreq_ready = bad ? !loc_busy
                      : (mreq_remote ? hdr_free : loc_go); // RL9
    wire mtake = mreq_valid && mreq_ready;
    wire rtake = mtake && !bad && mreq_remote;
    wire btake = mtake && bad;
    wire fab_write = pick_lnk ? lnk_write : mreq_write;
    wire [AW-1:0] fab_addr = pick_lnk ? lnk_addr : mreq_addr;
    wire [DW-1:0] fab_wdata = pick_lnk ? lnk_wdata : mreq_wdata;

    // Configuration fabric, shared by local and link requests
    eum_cfg_fabric u_fab (
        .clk(clk),
        .rst(rst),
        .req_valid(fab_valid),
        .req_ready(fab_ready),
        .req_write(fab_write),
        .req_addr(fab_addr),
        .req_wdata(fab_wdata),
        .rsp_valid(fab_rsp),
        .rsp_rdata(fab_rdata),
        .s_valid(cs_valid),
        .s_write(cs_write),
        .s_addr(cs_addr),
        .s_wdata(cs_wdata),
        .s_ready(cs_ready),
        .s_rdata(cs_rdata)
    );

    // Fairness toggle and ownership of the outstanding access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pref_lnk <= 1'b0;
            own_lnk <= 1'b0;
            loc_busy <= 1'b0;
        end else begin
            if (fab_take) begin
                pref_lnk <= !pick_lnk;
                own_lnk <= pick_lnk;
            end
            if (loc_go && mreq_valid)
                loc_busy <= 1'b1;
            else if (fab_rsp && !own_lnk)
                loc_busy <= 1'b0;
        end
    end

    // Responses back to their originators
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mrsp_valid <= 1'b0;
            mrsp_err <= 1'b0;
            mrsp_rdata <= RD_ZERO;
            lnk_rsp_valid <= 1'b0;
            lnk_rsp_rdata <= RD_ZERO;
        end else begin
            mrsp_valid <= btake || (fab_rsp && !own_lnk);
            mrsp_err <= btake; // RL8
            mrsp_rdata <= btake ? RD_ZERO : fab_rdata;
            lnk_rsp_valid <= fab_rsp && own_lnk;
            lnk_rsp_rdata <= fab_rdata;
        end
    end

    // Request information register, little-endian field layout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inf_dest <= 16'h0000;
            inf_prio <= 2'h0;
            inf_crf <= 1'b0;
            tid_cnt <= 8'h00;
        end else if (info_wr) begin
            inf_dest <= info_wdata[INF_DEST_LSB +: 16]; // RL15
            inf_prio <= info_wdata[INF_PRIO_LSB +: 2];
            inf_crf <= info_wdata[INF_CRF_BIT];
            tid_cnt <= info_wdata[INF_TID_LSB +: 8];
        end else if (rtake) begin
            tid_cnt <= tid_cnt + 8'h01; // RL11
        end
    end

    // Outgoing header slot for remote configuration requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_valid <= 1'b0;
            hdr_write <= 1'b0;
            hdr_destid <= 16'h0000;
            hdr_tid <= 8'h00;
            hdr_prio <= 2'h0;
            hdr_crf <= 1'b0;
            hdr_addr <= '0;
            hdr_wdata <= RD_ZERO;
        end else if (rtake) begin
            hdr_valid <= 1'b1;
            hdr_write <= mreq_write;
            hdr_destid <= inf_dest; // RL10
            hdr_tid <= tid_cnt;
            hdr_prio <= inf_prio;
            hdr_crf <= inf_crf;
            hdr_addr <= mreq_addr;
            hdr_wdata <= mreq_wdata;
        end else if (hdr_ready) begin
            hdr_valid <= 1'b0; // RL19
        end
    end

    // Receive steering: channel chosen on the first beat of a packet
    wire eum_chan_t dst = sop ? chan_of(rx_data[FT_LSB +: 4],
        rx_data[TT_LSB +: 4], io_it, msg_on_io) : out_chan; // RL7
    wire hello = fmt_hello[dst] && dst != CH_USER; // RL6
    wire sel_rdy = out_ready[out_chan];
    assign rx_ready = !out_valid || sel_rdy; // RL19
    wire rx_take = rx_valid && rx_ready;

    // Output register stage; header beat closes its own transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sop <= 1'b1;
            out_sop <= 1'b0;
            out_valid <= 1'b0;
            out_chan <= CH_IO_RX;
            out_data <= '0;
            out_last <= 1'b0;
            out_hdr <= 1'b0;
        end else if (rx_take) begin
            sop <= rx_last;
            out_sop <= sop;
            out_valid <= 1'b1;
            out_chan <= dst;
            out_data <= rx_data; // RL4
            out_hdr <= sop && hello; // RL2
            out_last <= rx_last || (sop && hello); // RL3
        end else if (sel_rdy) begin
            out_valid <= 1'b0;
        end
    end

    // Link control symbol requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mce_send <= 1'b0;
            lrst_send <= 1'b0;
        end else begin
            mce_send <= mce_req; // RL16
            lrst_send <= lrst_req; // RL17
        end
    end

    // Remote header carries the counted ID and info fields
    a_hdr_from_info: assert property (@(posedge clk) disable iff (rst) // RL10
        rtake && !info_wr |=> hdr_valid
            && hdr_destid == $past(inf_dest) && hdr_prio == $past(inf_prio))
        else $error("header fields not from info register");
    a_tid_step: assert property (@(posedge clk) disable iff (rst) // RL11
        rtake && !info_wr |=> tid_cnt == $past(tid_cnt) + 8'h01
            && hdr_tid == $past(tid_cnt))
        else $error("transaction ID did not advance");
    a_misalign_err: assert property (@(posedge clk) disable iff (rst) // RL9
        mtake && mis |=> mrsp_valid && mrsp_err)
        else $error("misaligned access not refused");
    a_lnk_fabric: assert property (@(posedge clk) disable iff (rst) // RL13
        lnk_valid && lnk_ready |=> own_lnk)
        else $error("link access bypassed fabric");
    a_user_steer: assert property (@(posedge clk) disable iff (rst) // RL7
        rx_take && sop && rx_data[FT_LSB +: 4] == 4'h8 |=> out_chan == CH_USER)
        else $error("unsupported type not on custom port");
    a_out_hold: assert property (@(posedge clk) disable iff (rst) // RL19
        out_valid && !sel_rdy |=> out_valid && $stable(out_data)
            && $stable(out_chan))
        else $error("beat lost under back-pressure");
    a_condensed: assert property (@(posedge clk) disable iff (rst) // RL1
        out_valid && out_sop && !io_it |-> out_chan != CH_TREQ
            && out_chan != CH_IRESP)
        else $error("initiator/target channel used in condensed style");
    a_hello_split: assert property (@(posedge clk) disable iff (rst) // RL3
        out_valid && out_hdr |-> out_last && out_chan != CH_USER)
        else $error("header not a separate transfer");
endmodule

// [hdl/eum_pkg.sv]
// Shared constants and types for the endpoint user-port block
package eum_pkg;
    // Widths
    localparam int AW = 24;
    localparam int DW = 32;
    localparam int RDW = 64;
    localparam int ALN_BITS = 2;
    // Packet format types, position of type fields in the first beat
    localparam logic [3:0] FT_NREAD = 4'h2;
    localparam logic [3:0] FT_NWRITE = 4'h5;
    localparam logic [3:0] FT_SWRITE = 4'h6;
    localparam logic [3:0] FT_DBELL = 4'ha;
    localparam logic [3:0] FT_MSG = 4'hb;
    localparam logic [3:0] FT_RESP = 4'hd;
    localparam logic [3:0] TT_MSG_RSP = 4'h1;
    localparam int FT_LSB = 48;
    localparam int TT_LSB = 44;
    // Request information word, bit 31 is the leftmost bit
    localparam int INF_DEST_LSB = 16;
    localparam int INF_TID_LSB = 8;
    localparam int INF_PRIO_LSB = 6;
    localparam int INF_CRF_BIT = 5;
    // Configuration fabric regions, selected by the upper address byte
    localparam int RG_LSB = 16;
    localparam logic [7:0] RG_LOG = 8'h00;
    localparam logic [7:0] RG_BUF = 8'h01;
    localparam logic [7:0] RG_PHY = 8'h02;
    localparam logic [DW-1:0] RD_ZERO = 32'h0000_0000;
    // Receive channels
    localparam int CH_N = 6;
    typedef enum logic [2:0] {
        CH_IO_RX, CH_TREQ, CH_IRESP, CH_MSG_TREQ, CH_MSG_IRESP, CH_USER
    } eum_chan_t;
    // Fabric slaves and states
    localparam int SLV_N = 3;
    typedef enum logic [1:0] {SLV_LOG, SLV_BUF, SLV_PHY, SLV_NONE} eum_slv_t;
    typedef enum logic {FS_IDLE, FS_ACC} eum_fab_t;
endpackage

// [hdl/eum_cfg_fabric.sv]
// Configuration fabric: routes maintenance accesses to layer slaves
`timescale 1ns/1ns
module eum_cfg_fabric (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request from the configuration master port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [eum_pkg::AW-1:0] req_addr,
    input wire logic [eum_pkg::DW-1:0] req_wdata,
    // Response
    output logic rsp_valid,
    output logic [eum_pkg::DW-1:0] rsp_rdata,
    // Layer slaves
    output logic [eum_pkg::SLV_N-1:0] s_valid,
    output logic s_write,
    output logic [eum_pkg::AW-1:0] s_addr,
    output logic [eum_pkg::DW-1:0] s_wdata,
    input wire logic [eum_pkg::SLV_N-1:0] s_ready,
    input wire logic [eum_pkg::SLV_N*eum_pkg::DW-1:0] s_rdata
);
    import eum_pkg::*;

    eum_fab_t st;
    eum_slv_t tgt;

    // Region decode of a configuration address
    function automatic eum_slv_t slv_of(input logic [AW-1:0] a);
        unique case (a[RG_LSB +: 8])
            RG_LOG: slv_of = SLV_LOG;
            RG_BUF: slv_of = SLV_BUF;
            RG_PHY: slv_of = SLV_PHY;
            default: slv_of = SLV_NONE;
        endcase
    endfunction

    // Decode and handshake
    wire eum_slv_t dec = slv_of(req_addr);
    wire take = req_valid && req_ready;
    wire done = (st == FS_ACC) && s_ready[tgt[1:0]];
    assign req_ready = (st == FS_IDLE);

    // One access at a time; out-of-range accesses answer zero at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= FS_IDLE;
            tgt <= SLV_NONE;
            s_valid <= '0;
            s_write <= 1'b0;
            s_addr <= '0;
            s_wdata <= '0;
            rsp_valid <= 1'b0;
            rsp_rdata <= RD_ZERO;
        end else begin
            rsp_valid <= 1'b0;
            unique case (st)
                FS_IDLE: if (take) begin
                    if (dec == SLV_NONE) begin
                        rsp_valid <= 1'b1; // RL18
                        rsp_rdata <= RD_ZERO; // RL18
                    end else begin
                        st <= FS_ACC;
                        tgt <= dec;
                        s_valid <= SLV_N'(1) << dec; // RL14
                        s_write <= req_write;
                        s_addr <= req_addr;
                        s_wdata <= req_wdata;
                    end
                end
                FS_ACC: if (done) begin
                    st <= FS_IDLE;
                    s_valid <= '0;
                    rsp_valid <= 1'b1;
                    rsp_rdata <= s_write ? RD_ZERO
                                         : s_rdata[tgt*DW +: DW];
                end
            endcase
        end
    end

    // Invalid address: no slave strobe, zero answer next cycle
    a_bad_addr_zero: assert property (@(posedge clk) disable iff (rst) // RL18
        take && dec == SLV_NONE |=> rsp_valid && rsp_rdata == RD_ZERO
            && s_valid == '0)
        else $error("invalid address not answered with zero");
    // Exactly one slave is strobed while an access runs
    a_one_slave: assert property (@(posedge clk) disable iff (rst) // RL14
        st == FS_ACC |-> $onehot(s_valid))
        else $error("slave strobe not one-hot");
    // Slave acknowledge yields a response in the next cycle
    a_ack_resp: assert property (@(posedge clk) disable iff (rst) // RL13
        done |=> rsp_valid && st == FS_IDLE)
        else $error("slave acknowledge lost");
endmodule

// [tb/eum_cfg_slaves.sv]
// Configuration slave model that answers the fabric
`timescale 1ns/1ns
module eum_cfg_slaves (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Answer delay in cycles
    input wire logic [3:0] dly,
    // Slave side of the configuration bus
    input wire logic [eum_pkg::SLV_N-1:0] cs_valid,
    input wire logic cs_write,
    input wire logic [eum_pkg::AW-1:0] cs_addr,
    input wire logic [eum_pkg::DW-1:0] cs_wdata,
    output logic [eum_pkg::SLV_N-1:0] cs_ready,
    output logic [eum_pkg::SLV_N*eum_pkg::DW-1:0] cs_rdata
);
    import eum_pkg::*;
    logic [DW-1:0] mem [SLV_N][16];
    logic [3:0] cnt [SLV_N];
    logic [3:0] cyc;
    // Each slave waits dly cycles, then takes one 32-bit word
    always @(posedge clk or posedge rst) begin
        cyc <= rst ? 4'h0 : cyc + 4'h1;
        for (int n = 0; n < SLV_N; n++) begin
            if (rst) begin
                cs_ready[n] <= 1'b0;
                cnt[n] <= 4'h0;
            end else if (cs_ready[n]) begin
                cs_ready[n] <= 1'b0;
                cnt[n] <= 4'h0;
                if (cs_write) mem[n][cs_addr[5:2]] <= cs_wdata;
            end else if (cs_valid[n]) begin
                cnt[n] <= cnt[n] + 4'h1;
                cs_ready[n] <= (cnt[n] >= dly);
            end
        end
    end
    // Read data means something only beside ready; else it keeps moving
    always_comb begin
        for (int n = 0; n < SLV_N; n++)
            cs_rdata[n*DW +: DW] = cs_ready[n] ? mem[n][cs_addr[5:2]] : {8{cyc}};
    end
endmodule

// [tb/test_eum_top.sv]
// Self-checking bench for the endpoint user-port block
`timescale 1ns/1ns
module test_eum_top;
    import eum_pkg::*;
    logic clk, rst, io_it, msg_on_io, maint_lite, info_wr;
    logic [CH_N-1:0] fmt_hello, out_ready;
    logic mreq_valid, mreq_ready, mreq_write, mreq_remote, mrsp_valid;
    logic [AW-1:0] mreq_addr, hdr_addr, lnk_addr, cs_addr;
    logic [DW-1:0] mreq_wdata, mrsp_rdata, info_wdata, hdr_wdata;
    logic [DW-1:0] lnk_wdata, lnk_rsp_rdata, cs_wdata, info;
    logic mrsp_err, hdr_valid, hdr_ready, hdr_write, hdr_crf, cs_write;
    logic [15:0] hdr_destid;
    logic [7:0] hdr_tid, tid;
    logic [1:0] hdr_prio;
    logic lnk_valid, lnk_ready, lnk_write, lnk_rsp_valid;
    logic [SLV_N-1:0] cs_valid, cs_ready;
    logic [SLV_N*DW-1:0] cs_rdata;
    logic rx_valid, rx_ready, rx_last, out_valid, out_last, out_hdr;
    logic [RDW-1:0] rx_data, out_data;
    eum_chan_t out_chan;
    logic mce_req, mce_send, lrst_req, lrst_send, p_mce, p_lrst;
    logic [3:0] dly;
    logic [127:0] e;
    logic [127:0] q_rsp[$], q_lnk[$], q_hdr[$], q_out[$];
    logic [DW-1:0] emem [SLV_N][16];
    int n_fail = 0;
    int num_checks = 0;

    eum_top dut (.*);
    eum_cfg_slaves slaves (.*);

    // Free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [127:0] x, s);
        num_checks++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Oldest note, or unknown when nothing was expected
    function automatic logic [127:0] pop(ref logic [127:0] q[$]);
        return q.size() > 0 ? q.pop_front() : 'x;
    endfunction

    // Local view of slave contents; unmapped space reads zero
    function automatic logic [DW-1:0] acc(input logic w,
        input logic [AW-1:0] a, input logic [DW-1:0] d);
        if (a[RG_LSB +: 8] > RG_PHY) return '0;
        if (w) emem[a[17:16]][a[5:2]] = d;
        return w ? '0 : emem[a[17:16]][a[5:2]];
    endfunction

    // Receive channel that a first beat should be steered to
    function automatic eum_chan_t chan_of(input logic [3:0] ft, tt);
        eum_chan_t rq;
        eum_chan_t rs;
        rq = io_it ? CH_TREQ : CH_IO_RX;
        rs = io_it ? CH_IRESP : CH_IO_RX;
        if (ft inside {FT_NREAD, FT_NWRITE, FT_SWRITE, FT_DBELL}) return rq;
        if (ft == FT_MSG) return msg_on_io ? rq : CH_MSG_TREQ;
        if (ft == FT_RESP && tt == TT_MSG_RSP) return msg_on_io ? rs : CH_MSG_IRESP;
        if (ft == FT_RESP) return rs;
        return CH_USER;
    endfunction

    // Holds a request until the edge where its ready is high
    task automatic take(input int w);
        int k = 0;
        do @(negedge clk);
        while ((w == 0 ? mreq_ready : w == 1 ? lnk_ready : rx_ready) !== 1'b1
            && ++k < 400);
        @(posedge clk);
        #2;
    endtask

    task automatic mreq(input logic w, r, input logic [AW-1:0] a,
        input logic [DW-1:0] d);
        {mreq_valid, mreq_write, mreq_remote, mreq_addr, mreq_wdata} =
            {1'b1, w, r, a, d};
        if (a[1:0] != 2'b00 || (!maint_lite && !r))
            q_rsp.push_back({2'b01, 32'h0000_0000});
        else if (r) begin
            q_hdr.push_back({w, info[31:16], tid, info[7:6], info[5], a, d});
            tid++;
        end else q_rsp.push_back({2'b10, acc(w, a, d)});
        take(0);
    endtask

    task automatic lnk(input logic w, input logic [AW-1:0] a,
        input logic [DW-1:0] d);
        {lnk_valid, lnk_write, lnk_addr, lnk_wdata} = {1'b1, w, a, d};
        q_lnk.push_back(acc(w, a, d));
        take(1);
    endtask

    task automatic pkt(input logic [3:0] ft, tt, input int nb);
        eum_chan_t c;
        logic u;
        c = chan_of(ft, tt);
        u = fmt_hello[c] && c != CH_USER;
        for (int b = 0; b < nb; b++) begin
            rx_valid = 1'b1;
            rx_data = {$urandom, $urandom};
            if (b == 0) rx_data[TT_LSB +: 8] = {ft, tt};
            rx_last = (b == nb - 1);
            q_out.push_back({c, u && b == 0, rx_last || (u && b == 0), rx_data});
            take(2);
        end
    endtask

    task automatic end_test(input string nm);
        int k = 0;
        {mreq_valid, lnk_valid, rx_valid} = 3'b000;
        while (q_rsp.size() + q_lnk.size() + q_hdr.size() + q_out.size() > 0
            && ++k < 400) @(posedge clk);
        repeat (2) @(posedge clk);
        #2;
        chk("pending", 0, q_rsp.size() + q_lnk.size() + q_hdr.size()
            + q_out.size());
        $display("test %s done", nm);
    endtask

    // Compares each result with the oldest note of its kind
    always @(posedge clk) begin
        // Requests seen under reset never reach the outputs
        p_mce <= mce_req && !rst;
        p_lrst <= lrst_req && !rst;
        if (!rst) begin
            chk("mce_send", p_mce, mce_send);
            chk("lrst_send", p_lrst, lrst_send);
            if (mrsp_valid) begin
                e = pop(q_rsp);
                chk("mrsp_err", e[32], mrsp_err);
                chk("mrsp_rdata", e[31:0], mrsp_rdata);
            end
            if (lnk_rsp_valid) chk("lnk_rsp", pop(q_lnk), lnk_rsp_rdata);
            if (hdr_valid && hdr_ready) chk("hdr", pop(q_hdr), {hdr_write,
                hdr_destid, hdr_tid, hdr_prio, hdr_crf, hdr_addr, hdr_wdata});
            if (out_valid && out_ready[out_chan]) chk("out", pop(q_out),
                {out_chan, out_hdr, out_last, out_data});
        end
    end

    // Far side stalls at random; event pulses last one cycle
    always @(posedge clk) begin
        #2;
        hdr_ready = 1'($urandom_range(1));
        out_ready = 6'($urandom);
        dly = 4'($urandom_range(3));
        mce_req = !mce_req && ($urandom_range(7) == 0);
        if ($urandom_range(15) == 0) lrst_req = ~lrst_req;
    end

    // Watchdog: the tests need a few thousand cycles at most
    initial begin
        #(50 * 20000);
        n_fail++;
        test_done;
    end

    initial begin
        {mreq_valid, mreq_write, mreq_remote, info_wr, hdr_ready, lnk_valid,
            lnk_write, rx_valid, rx_last, mce_req, lrst_req, io_it} = '0;
        {msg_on_io, mreq_addr, mreq_wdata, info_wdata, lnk_addr, lnk_wdata,
            rx_data, fmt_hello, out_ready, dly} = '0;
        {rst, maint_lite} = 2'b11;
        void'($urandom(36201));
        repeat (10) @(posedge clk);
        #2;
        rst = 1'b0;
        // Local and link-partner words through all regions, side by side
        fork
            for (int i = 0; i < 12; i++) begin
                mreq(1'b1, 1'b0, {8'(i % 4), 10'h000, 4'(i / 4), 2'b00}, $urandom);
                mreq(1'b0, 1'b0, {8'(i % 4), 10'h000, 4'(i / 4), 2'b00}, '0);
                mreq(1'b0, 1'b0, {8'(i % 4), 10'h000, 4'(i / 4), 2'b10}, '0);
            end
            for (int i = 0; i < 8; i++) begin
                lnk(1'b1, {8'(i % 4), 10'h000, 4'(8 + i / 4), 2'b00}, $urandom);
                lnk(1'b0, {8'(i % 4), 10'h000, 4'(8 + i / 4), 2'b00}, '0);
            end
        join
        end_test("local and link");
        // One information write serves a run of remote requests
        info = $urandom;
        info_wdata = info;
        info_wr = 1'b1;
        @(posedge clk);
        #2;
        info_wr = 1'b0;
        tid = info[15:8];
        for (int i = 0; i < 20; i++)
            mreq(i[0], 1'b1, 24'($urandom) & 24'hff_fffc, i[0] ? $urandom : '0);
        end_test("remote headers");
        // Stream mode refuses local targets but keeps remote ones
        maint_lite = 1'b0;
        for (int i = 0; i < 6; i++) mreq(1'b0, i[0], 24'h00_0010, '0);
        end_test("stream maintenance");
        // Every packet type under each port style and message routing, each pairing with one random format mix
        for (int g = 0; g < 4; g++) begin
            {io_it, msg_on_io} = 2'(g);
            fmt_hello = 6'($urandom);
            for (int f = 0; f < 16; f++)
                pkt(4'(f), 4'($urandom_range(1)), 1 + $urandom_range(2));
            end_test("receive steering");
        end
        test_done;
    end
endmodule
